/* File: hw/msq_device.sv */
// Controller end: phase offset, chained sequencing and fault spreading
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// [R1] Offset is address low three bits times 45
// [R2] Command overrides offset in 22.5 degree steps
// [R3] Sharing group staggers offsets automatically
// [R4] All members switch from one common clock
// [R5] Host programs neighbours; wait for predecessor
// [R6] Enable rise powers up, fall powers down
// [R7] Enables and coordination lines wired together
// [R8] Timer-only mode starts regardless of predecessor
// [R9] Timer-only start carries up to 4 ms skew
// [R10] Local fault shuts down and broadcasts
// [R11] Broadcast fault shuts down, optional restart
// [R12] Aborted command locks bus until re-enable
// [R13] Setup bit makes coordination pin push-pull
// [R14] Line pulled up before enable rises
// [R15] Hold enable low under command control
// [R16] Alert line tells host of faults
// [R17] Pulse length code for faults and handoffs
module msq_device #(
	parameter int unsigned SKEW_CYC = msq_pkg::SKEW_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	msq_coord_if.dev link,
	input wire logic [6:0] dev_addr,
	input wire logic fault_in,
	output logic rail_on,
	output logic power_good,
	output logic [4:0] phase_offset,
	output logic pwm_start
);
	typedef enum logic [7:0] {
		S_OFF = 8'h01,
		S_WAIT_PREV = 8'h02,
		S_DELAY = 8'h04,
		S_RISE = 8'h08,
		S_ON = 8'h10,
		S_WAIT_NEXT = 8'h20,
		S_FALL = 8'h40,
		S_FAULT = 8'h80
	} msq_state_type;

	// ****************************************
	// Configuration from management commands
	// ****************************************
	logic [3:0] addr_reg;
	logic addr_cap_reg;
	logic ph_ovr_reg;
	logic [4:0] ph_val_reg;
	logic [3:0] prev_reg;
	logic [3:0] next_reg;
	logic has_prev_reg;
	logic has_next_reg;
	logic [5:0] setup_reg;
	logic [15:0] ton_reg;
	logic [15:0] trise_reg;
	logic on_cmd_reg;
	logic lock_reg;
	logic lock_off_reg;

	wire cmd_ok = link.mgmt_wr && !lock_reg;
	wire [15:0] d = link.mgmt_data;
	wire wr_ph = cmd_ok && link.mgmt_code == msq_pkg::CMD_PHASE && d[4:0] <= msq_pkg::PH_MAX;
	wire wr_seq = cmd_ok && link.mgmt_code == msq_pkg::CMD_SEQ;
	wire wr_su = cmd_ok && link.mgmt_code == msq_pkg::CMD_SETUP;
	wire wr_ton = cmd_ok && link.mgmt_code == msq_pkg::CMD_TON;
	wire wr_tr = cmd_ok && link.mgmt_code == msq_pkg::CMD_TRISE;
	wire wr_on = cmd_ok && link.mgmt_code == msq_pkg::CMD_ONOFF;
	wire wr_clr = cmd_ok && link.mgmt_code == msq_pkg::CMD_CLRALERT;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg <= 4'h0;
			addr_cap_reg <= 1'b0;
			ph_ovr_reg <= 1'b0;
			ph_val_reg <= 5'h00;
			prev_reg <= 4'h0;
			next_reg <= 4'h0;
			has_prev_reg <= 1'b0;
			has_next_reg <= 1'b0;
			setup_reg <= msq_pkg::SETUP_RST;
			ton_reg <= msq_pkg::TON_RST;
			trise_reg <= msq_pkg::TRISE_RST;
			on_cmd_reg <= 1'b0;
		end else begin
			// Strap caught once, on the first edge after release
			if (!addr_cap_reg) begin
				addr_reg <= dev_addr[3:0];
				addr_cap_reg <= 1'b1;
			end
			if (wr_ph) begin
				ph_ovr_reg <= d[msq_pkg::PH_OVR_BIT]; // [R2]
				ph_val_reg <= d[4:0]; // [R2]
			end
			if (wr_seq) begin
				prev_reg <= d[3:0]; // [R5]
				next_reg <= d[msq_pkg::SEQ_NEXT_LSB +: 4]; // [R5]
				has_prev_reg <= d[msq_pkg::SEQ_HASPREV_BIT];
				has_next_reg <= d[msq_pkg::SEQ_HASNEXT_BIT];
			end
			if (wr_su)
				setup_reg <= d[5:0];
			if (wr_ton)
				ton_reg <= d;
			if (wr_tr)
				trise_reg <= d;
			if (wr_on)
				on_cmd_reg <= d[0];
		end
	end

	// Lock after an aborted command; freed by enable going low then high
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lock_reg <= 1'b0;
			lock_off_reg <= 1'b0;
		end else begin
			if (link.mgmt_abort)
				lock_reg <= 1'b1; // [R12]
			else if (lock_off_reg && link.en)
				lock_reg <= 1'b0; // [R12]
			lock_off_reg <= lock_reg && !link.mgmt_abort && (lock_off_reg || !link.en);
		end
	end

	// ****************************************
	// Phase offset, units of 22.5 degrees
	// ****************************************
	logic [3:0] ph_pos_reg;
	wire [4:0] addr_ofs = {1'b0, addr_reg[2:0], 1'b0}; // [R1]
	wire [4:0] share_ofs = {2'b00, addr_reg[1:0], 1'b0}; // [R3]
	wire [4:0] ofs_next = ph_ovr_reg ? ph_val_reg :
		(setup_reg[msq_pkg::SU_SHARE] ? share_ofs : addr_ofs);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ph_pos_reg <= 4'h0;
			phase_offset <= 5'h00;
			pwm_start <= 1'b0;
		end else begin
			// Period position restarts on the common switching sync [R4]
			ph_pos_reg <= link.sync ? 4'h0 : ph_pos_reg + 4'h1;
			phase_offset <= ofs_next;
			// 360 degrees wraps onto 0
			pwm_start <= (link.sync ? 4'h0 : ph_pos_reg + 4'h1) == ofs_next[3:0];
		end
	end

	// ****************************************
	// Coordination line transmit and receive
	// ****************************************
	logic [7:0] tx_cnt_reg;
	logic hand_pend_reg;
	logic flt_pend_reg;
	logic [7:0] rx_cnt_reg;
	logic line_d_reg;
	logic hand_req;
	logic flt_req;

	wire tx_idle = tx_cnt_reg == 8'h00;
	wire tx_low = tx_cnt_reg > msq_pkg::GAP_CYC;
	// Fault goes before a waiting handoff
	wire [7:0] hand_len = 8'({4'h0, addr_reg} + 8'h01) * msq_pkg::UNIT_CYC;
	wire [7:0] tx_load = flt_pend_reg ? msq_pkg::FAULT_CYC : hand_len; // [R17]
	wire rx_done = link.line && !line_d_reg && tx_idle && rx_cnt_reg != 8'h00;
	wire rx_fault = rx_done && rx_cnt_reg >= msq_pkg::FAULT_MIN; // [R17]
	wire rx_hand = rx_done && !rx_fault;
	wire [3:0] rx_id = msq_pkg::pulse_id(rx_cnt_reg);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt_reg <= 8'h00;
			hand_pend_reg <= 1'b0;
			flt_pend_reg <= 1'b0;
			rx_cnt_reg <= 8'h00;
			line_d_reg <= 1'b1;
		end else begin
			hand_pend_reg <= hand_req || (hand_pend_reg && !(tx_idle && !flt_pend_reg));
			flt_pend_reg <= flt_req || (flt_pend_reg && !tx_idle);
			if (tx_idle && (hand_pend_reg || flt_pend_reg))
				tx_cnt_reg <= tx_load + msq_pkg::GAP_CYC;
			else if (!tx_idle)
				tx_cnt_reg <= tx_cnt_reg - 8'h01;
			line_d_reg <= link.line;
			// Own pulses are not measured
			if (link.line || !tx_idle)
				rx_cnt_reg <= 8'h00;
			else if (rx_cnt_reg != 8'hFF)
				rx_cnt_reg <= rx_cnt_reg + 8'h01;
		end
	end

	// Open drain unless set push-pull for standalone use
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			link.dev_o <= 1'b0;
			link.dev_oe <= 1'b0;
		end else begin
			link.dev_o <= setup_reg[msq_pkg::SU_PUSHPULL] && !tx_low; // [R13]
			link.dev_oe <= setup_reg[msq_pkg::SU_PUSHPULL] || tx_low; // [R13]
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	msq_state_type state_reg;
	msq_state_type state_next;
	logic [31:0] tmr_reg;
	logic [31:0] tmr_next;
	logic [31:0] skew_reg;
	logic run_d_reg;
	logic alert_reg;

	wire run = setup_reg[msq_pkg::SU_CMD_ON] ? on_cmd_reg : link.en;
	wire run_rise = run && !run_d_reg;
	wire run_fall = !run && run_d_reg;
	wire tmr_zero = tmr_reg == 32'h0;
	wire timer_only = !has_prev_reg && !has_next_reg;
	wire loc_flt = fault_in && setup_reg[msq_pkg::SU_FLT_SHUT];
	wire obey_flt = rx_fault && setup_reg[msq_pkg::SU_FLT_OBEY];
	wire active = !(state_reg inside {S_OFF, S_FAULT});
	wire [31:0] ton32 = {16'h0, ton_reg};
	wire [31:0] tr32 = {16'h0, trise_reg};
	// Unsynchronised peers start anywhere within the skew window
	wire [31:0] start_dly = timer_only ? ton32 + skew_reg : ton32; // [R9]

	always_comb begin
		state_next = state_reg;
		tmr_next = tmr_zero ? 32'h0 : tmr_reg - 32'h1;
		hand_req = 1'b0;
		flt_req = 1'b0;
		if (active && loc_flt) begin
			state_next = S_FAULT; // [R10]
			flt_req = 1'b1; // [R10]
			tmr_next = 32'(msq_pkg::RESTART_CYC);
		end else if (active && obey_flt) begin
			state_next = S_FAULT; // [R11]
			tmr_next = 32'(msq_pkg::RESTART_CYC);
		end else begin
			unique case (state_reg)
				S_OFF: begin
					if (run_rise && has_prev_reg) begin
						state_next = S_WAIT_PREV; // [R6] [R5]
					end else if (run_rise) begin
						state_next = S_DELAY; // [R6] [R8]
						tmr_next = start_dly;
					end
				end
				S_WAIT_PREV: begin
					if (!run) begin
						state_next = S_OFF;
					end else if (rx_hand && rx_id == prev_reg) begin
						state_next = S_DELAY; // [R5]
						tmr_next = ton32;
					end
				end
				S_DELAY: begin
					if (!run) begin
						state_next = S_OFF;
					end else if (tmr_zero) begin
						state_next = S_RISE;
						tmr_next = tr32;
					end
				end
				S_RISE: begin
					if (!run) begin
						state_next = S_FALL;
						tmr_next = tr32;
					end else if (tmr_zero) begin
						state_next = S_ON;
						hand_req = 1'b1; // [R17]
					end
				end
				S_ON: begin
					if (run_fall || !run) begin
						state_next = has_next_reg ? S_WAIT_NEXT : S_FALL; // [R6]
						tmr_next = tr32;
					end
				end
				S_WAIT_NEXT: begin
					// Power-down runs the chain backwards
					if (rx_hand && rx_id == next_reg) begin
						state_next = S_FALL;
						tmr_next = tr32;
					end else if (run) begin
						state_next = S_ON;
					end
				end
				S_FALL: begin
					if (tmr_zero) begin
						state_next = S_OFF;
						hand_req = has_prev_reg;
					end
				end
				S_FAULT: begin
					if (!run) begin
						state_next = S_OFF;
					end else if (setup_reg[msq_pkg::SU_RESTART] && tmr_zero) begin
						// Rejoin in chain order
						state_next = has_prev_reg ? S_WAIT_PREV : S_DELAY; // [R11]
						tmr_next = start_dly;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_OFF;
			tmr_reg <= 32'h0;
			skew_reg <= 32'h0;
			run_d_reg <= 1'b0;
			alert_reg <= 1'b0;
			rail_on <= 1'b0;
			power_good <= 1'b0;
			link.alert <= 1'b0;
		end else begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			skew_reg <= (skew_reg >= 32'(SKEW_CYC - 1)) ? 32'h0 : skew_reg + 32'h1; // [R9]
			run_d_reg <= run;
			// Set wins over a clear in the same cycle
			alert_reg <= (fault_in || rx_fault) || (alert_reg && !wr_clr); // [R16]
			link.alert <= (fault_in || rx_fault) || (alert_reg && !wr_clr); // [R16]
			rail_on <= state_next inside {S_RISE, S_ON, S_WAIT_NEXT, S_FALL};
			power_good <= state_next inside {S_ON, S_WAIT_NEXT};
		end
	end
endmodule

/* File: inc/msq_pkg.sv */
// Shared constants for the rail sequence and phase coordination ends
package msq_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned SKEW_MS = 4;
	localparam int unsigned SKEW_CYC = SKEW_MS * CLK_KHZ;
	localparam int unsigned RESTART_US = 40;
	localparam int unsigned RESTART_CYC = RESTART_US * CLK_MHZ;
	localparam int unsigned SYNC_PERIOD = 16;
	// ****************************************
	// Coordination line pulse code
	// ****************************************
	localparam logic [7:0] UNIT_CYC = 8'h04;
	localparam logic [7:0] GAP_CYC = 8'h08;
	localparam logic [7:0] FAULT_CYC = 8'hA0;
	localparam logic [7:0] FAULT_MIN = 8'h90;
	// ****************************************
	// Management commands
	// ****************************************
	localparam logic [3:0] CMD_PHASE = 4'h1;
	localparam logic [3:0] CMD_SEQ = 4'h2;
	localparam logic [3:0] CMD_SETUP = 4'h3;
	localparam logic [3:0] CMD_TON = 4'h4;
	localparam logic [3:0] CMD_TRISE = 4'h5;
	localparam logic [3:0] CMD_ONOFF = 4'h6;
	localparam logic [3:0] CMD_CLRALERT = 4'h7;
	localparam int unsigned PH_OVR_BIT = 5;
	localparam logic [4:0] PH_MAX = 5'h10;
	localparam int unsigned SEQ_NEXT_LSB = 4;
	localparam int unsigned SEQ_HASPREV_BIT = 8;
	localparam int unsigned SEQ_HASNEXT_BIT = 9;
	localparam int unsigned SU_PUSHPULL = 0;
	localparam int unsigned SU_FLT_SHUT = 1;
	localparam int unsigned SU_FLT_OBEY = 2;
	localparam int unsigned SU_RESTART = 3;
	localparam int unsigned SU_SHARE = 4;
	localparam int unsigned SU_CMD_ON = 5;
	localparam logic [5:0] SETUP_RST = 6'h06;
	localparam logic [15:0] TON_RST = 16'h0064;
	localparam logic [15:0] TRISE_RST = 16'h00C8;
	// ****************************************
	// Controller registers
	// ****************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_IRQ_STAT = 8'h0C;
	localparam logic [7:0] A_IRQ_CLR = 8'h10;
	localparam logic [7:0] A_IRQ_EN = 8'h14;
	localparam logic [7:0] A_TX = 8'h18;
	localparam int unsigned CMD_ABORT_BIT = 20;
	localparam int unsigned TX_FAULT_BIT = 4;

	// Id carried by a low pulse of (id+1) units, rounded to nearest unit
	function automatic logic [3:0] pulse_id(input logic [7:0] len);
		logic [7:0] u;
		u = (len + 8'h02) >> 2;
		pulse_id = 4'(u - 8'h01);
	endfunction
endpackage

/* File: inc/msq_coord_if.sv */
// Shared enable, coordination line and management wires between both ends
`timescale 1ns/1ps
interface msq_coord_if;
	logic en;
	logic sync;
	logic mgmt_wr;
	logic mgmt_abort;
	logic [3:0] mgmt_code;
	logic [15:0] mgmt_data;
	logic alert;
	logic dev_o;
	logic dev_oe;
	logic host_o;
	logic host_oe;
	wire line;
	// Pulled up unless someone drives low; push-pull high adds nothing [R14] [R7]
	assign line = !((dev_oe && !dev_o) || (host_oe && !host_o));
	modport dev(input en, sync, mgmt_wr, mgmt_abort, mgmt_code, mgmt_data, line,
		output alert, dev_o, dev_oe);
	modport host(input alert, line, dev_o, dev_oe,
		output en, sync, mgmt_wr, mgmt_abort, mgmt_code, mgmt_data, host_o, host_oe);
endinterface

/* File: hw/msq_host.sv */
// Management end: AHB-Lite registers driving enable, commands and peer pulses
`timescale 1ns/1ps
module msq_host (
	input wire logic clock,
	input wire logic rst_n,
	msq_coord_if.host link,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq
);
	// ****************************************
	// Bus slave, zero wait states
	// ****************************************
	logic wr_pend_reg;
	logic [7:0] wa_reg;
	logic [1:0] ctrl_reg;
	logic [2:0] ist_reg;
	logic [2:0] ien_reg;
	logic [3:0] last_id_reg;
	logic [7:0] tx_cnt_reg;
	logic [7:0] rx_cnt_reg;
	logic line_d_reg;
	logic alert_d_reg;
	logic [3:0] sync_cnt_reg;

	wire take = hsel && htrans[1] && hready;
	wire w_ctrl = wr_pend_reg && wa_reg == msq_pkg::A_CTRL;
	wire w_cmd = wr_pend_reg && wa_reg == msq_pkg::A_CMD;
	wire w_clr = wr_pend_reg && wa_reg == msq_pkg::A_IRQ_CLR;
	wire w_ien = wr_pend_reg && wa_reg == msq_pkg::A_IRQ_EN;
	wire w_tx = wr_pend_reg && wa_reg == msq_pkg::A_TX && tx_cnt_reg == 8'h00;
	wire tx_low = tx_cnt_reg > msq_pkg::GAP_CYC;
	wire rx_done = link.line && !line_d_reg && rx_cnt_reg != 8'h00;
	wire rx_fault = rx_done && rx_cnt_reg >= msq_pkg::FAULT_MIN; // [R17]
	wire [2:0] ev = {rx_done && !rx_fault, rx_fault, link.alert && !alert_d_reg};
	wire [2:0] ist_next = ev | (ist_reg & ~(w_clr ? hwdata[2:0] : 3'h0));
	wire [7:0] tx_len = hwdata[msq_pkg::TX_FAULT_BIT] ? msq_pkg::FAULT_CYC :
		8'({4'h0, hwdata[3:0]} + 8'h01) * msq_pkg::UNIT_CYC; // [R17]
	wire [31:0] rd_mux =
		(haddr[7:0] == msq_pkg::A_CTRL) ? {30'h0, ctrl_reg} :
		(haddr[7:0] == msq_pkg::A_STAT) ? {24'h0, last_id_reg, 1'b0,
			tx_cnt_reg != 8'h00, link.line, link.alert} :
		(haddr[7:0] == msq_pkg::A_IRQ_STAT) ? {29'h0, ist_reg} :
		(haddr[7:0] == msq_pkg::A_IRQ_EN) ? {29'h0, ien_reg} : 32'h0;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
			wa_reg <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_reg <= take && hwrite;
			wa_reg <= haddr[7:0];
			if (take && !hwrite)
				hrdata <= rd_mux;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ****************************************
	// Control, commands and interrupts
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= 2'b00;
			ist_reg <= 3'h0;
			ien_reg <= 3'h0;
			irq <= 1'b0;
			link.en <= 1'b0;
			link.mgmt_wr <= 1'b0;
			link.mgmt_abort <= 1'b0;
			link.mgmt_code <= 4'h0;
			link.mgmt_data <= 16'h0000;
		end else begin
			if (w_ctrl)
				ctrl_reg <= hwdata[1:0];
			if (w_ien)
				ien_reg <= hwdata[2:0];
			ist_reg <= ist_next;
			irq <= |(ist_next & (w_ien ? hwdata[2:0] : ien_reg));
			// Command-controlled turn-on keeps the pin grounded [R15]
			link.en <= w_ctrl ? (hwdata[0] && !hwdata[1]) : (ctrl_reg[0] && !ctrl_reg[1]);
			// Neighbour links and setup go out as plain commands [R5]
			link.mgmt_wr <= w_cmd && !hwdata[msq_pkg::CMD_ABORT_BIT];
			link.mgmt_abort <= w_cmd && hwdata[msq_pkg::CMD_ABORT_BIT];
			if (w_cmd) begin
				link.mgmt_code <= hwdata[19:16];
				link.mgmt_data <= hwdata[15:0];
			end
		end
	end

	// ****************************************
	// Peer pulses, monitor and switching sync
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt_reg <= 8'h00;
			rx_cnt_reg <= 8'h00;
			line_d_reg <= 1'b1;
			alert_d_reg <= 1'b0;
			last_id_reg <= 4'h0;
			sync_cnt_reg <= 4'h0;
			link.sync <= 1'b0;
			link.host_o <= 1'b0;
			link.host_oe <= 1'b0;
		end else begin
			// A send while busy is dropped
			if (w_tx)
				tx_cnt_reg <= tx_len + msq_pkg::GAP_CYC;
			else if (tx_cnt_reg != 8'h00)
				tx_cnt_reg <= tx_cnt_reg - 8'h01;
			link.host_o <= 1'b0;
			link.host_oe <= tx_low; // [R7]
			line_d_reg <= link.line;
			alert_d_reg <= link.alert;
			if (link.line)
				rx_cnt_reg <= 8'h00;
			else if (rx_cnt_reg != 8'hFF)
				rx_cnt_reg <= rx_cnt_reg + 8'h01;
			if (rx_done && !rx_fault)
				last_id_reg <= msq_pkg::pulse_id(rx_cnt_reg);
			// One sync for every member keeps offsets aligned [R4]
			sync_cnt_reg <= sync_cnt_reg + 4'h1;
			link.sync <= sync_cnt_reg == 4'(msq_pkg::SYNC_PERIOD - 1);
		end
	end
endmodule

/* File: dv/msq_checker.sv */
// Assertions on the coordination wires between both ends
`timescale 1ns/1ps
module msq_checker (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic en,
	input wire logic sync,
	input wire logic mgmt_wr,
	input wire logic mgmt_abort,
	input wire logic [3:0] mgmt_code,
	input wire logic [15:0] mgmt_data,
	input wire logic alert,
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic host_o,
	input wire logic host_oe,
	input wire logic line
);
	// ****
	// Pulse measurement
	// ****
	wire dev_low;
	wire clr_cmd;
	logic [8:0] dev_cnt_reg;
	logic [8:0] line_cnt_reg;
	logic lock_reg;
	logic pp_seen_reg;
	assign dev_low = dev_oe && !dev_o;
	assign clr_cmd = mgmt_wr && mgmt_code == msq_pkg::CMD_CLRALERT;
	function automatic logic len_ok(input logic [8:0] c);
		return (c[1:0] == 2'h0 && c >= 9'h004 && c <= 9'h040) || c == 9'h0A0;
	endfunction
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dev_cnt_reg <= 9'h000;
			line_cnt_reg <= 9'h000;
			lock_reg <= 1'b0;
			pp_seen_reg <= 1'b0;
		end else begin
			dev_cnt_reg <= dev_low ? dev_cnt_reg + 9'h001 : 9'h000;
			line_cnt_reg <= !line ? line_cnt_reg + 9'h001 : 9'h000;
			// Any low enable drops it: may miss a lock, never invents one
			lock_reg <= mgmt_abort || (lock_reg && en);
			pp_seen_reg <= pp_seen_reg || (mgmt_wr && mgmt_code == msq_pkg::CMD_SETUP
				&& mgmt_data[msq_pkg::SU_PUSHPULL]);
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ****
	// Properties
	// ****
	dev_pulse_len_a: assert property ($fell(dev_low) |-> len_ok(dev_cnt_reg))
		else $error("device pulse length outside code");
	dev_pulse_gap_a: assert property ($fell(dev_low) |-> (!dev_low) [*8])
		else $error("device gap after pulse too short");
	open_drain_a: assert property (!pp_seen_reg |-> !(dev_oe && dev_o))
		else $error("device drove line high in open drain");
	alert_fault_a: assert property (($rose(line) && line_cnt_reg >= 9'(msq_pkg::FAULT_MIN)
		&& line_cnt_reg <= 9'(msq_pkg::FAULT_CYC)) |-> ##[0:4] alert)
		else $error("no alert after fault pulse");
	alert_fall_a: assert property ($fell(alert) |-> $past(clr_cmd))
		else $error("alert dropped without clear");
	alert_lock_a: assert property ((lock_reg && en && alert && clr_cmd) |=> alert)
		else $error("clear taken while locked");
	sync_gap_a: assert property (sync |=> (!sync) [*8])
		else $error("sync pulses too close");
	sync_period_a: assert property (sync |-> ##16 sync)
		else $error("sync period wrong");
endmodule

/* File: dv/test_multi_rail_sequence_phase_coord.sv */
// Bench driving both ends joined by one coordination interface
`timescale 1ns/1ps
module test_multi_rail_sequence_phase_coord;
	// ****
	// Harness
	// ****
	localparam int SKEW = 16;
	localparam int TON = msq_pkg::TON_RST;
	localparam int TRISE = msq_pkg::TRISE_RST;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] dev_addr = 7'h00;
	logic fault_in = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic irq;
	logic rail_on;
	logic power_good;
	logic [4:0] phase_offset;
	logic pwm_start;
	logic [31:0] rd;
	logic [6:0] a;
	logic [4:0] pv;
	logic [3:0] p;
	logic [15:0] tv;
	logic [15:0] rv;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	assign hready = hreadyout;
	msq_coord_if link_if();
	msq_device #(.SKEW_CYC(SKEW)) u_msq_device (.clock(clock), .rst_n(rst_n), .link(link_if.dev),
		.dev_addr(dev_addr), .fault_in(fault_in), .rail_on(rail_on), .power_good(power_good),
		.phase_offset(phase_offset), .pwm_start(pwm_start));
	msq_host u_msq_host (.clock(clock), .rst_n(rst_n), .link(link_if.host), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
	msq_checker chk (.clock(clock), .rst_n(rst_n), .en(link_if.en), .sync(link_if.sync),
		.mgmt_wr(link_if.mgmt_wr), .mgmt_abort(link_if.mgmt_abort),
		.mgmt_code(link_if.mgmt_code), .mgmt_data(link_if.mgmt_data), .alert(link_if.alert),
		.dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe), .host_o(link_if.host_o),
		.host_oe(link_if.host_oe), .line(link_if.line));
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end
	task summarize;
		$display("Checks run %0d, failed %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	// Single word; either phase may be stretched by the slave
	task ahb(input logic [7:0] ad, input logic w, input logic [31:0] wd);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, ad};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task cmd(input logic [3:0] code, input logic [15:0] d, input logic ab);
		ahb(msq_pkg::A_CMD, 1'b1, {11'h000, ab, code, d});
	endtask
	task do_reset(input logic [6:0] ad);
		@(posedge clock);
		rst_n <= 1'b0;
		dev_addr <= ad;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		tick(3);
	endtask
	task wait_sig(input int sel, input logic v, input int lim);
		n = 0;
		while ((sel == 0 ? power_good : (sel == 1 ? rail_on : link_if.alert)) !== v && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	function automatic logic [4:0] exp_phase(input logic [6:0] ad, input logic share);
		return share ? {2'h0, ad[1:0], 1'b0} : {1'b0, ad[2:0], 1'b0};
	endfunction
	// ****
	// Scenarios
	// ****
	initial begin
		void'($urandom(94));
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 7'h0F : 7'($urandom());
			do_reset(a);
			check("phase_addr", phase_offset, exp_phase(a, 1'b0));
		end
		n = 0;
		repeat (32) begin
			tick(1);
			n += pwm_start;
		end
		check("pwm_rate", n, 2);
		cmd(msq_pkg::CMD_SETUP, {10'h0, msq_pkg::SETUP_RST | 6'h10}, 1'b0);
		tick(2);
		check("phase_share", phase_offset, exp_phase(a, 1'b1));
		do_reset(a);
		for (int i = 0; i < 3; i++) begin
			pv = (i == 0) ? 5'($urandom_range(15)) : 5'h0F + 5'(i);
			cmd(msq_pkg::CMD_PHASE, {10'h0, 1'b1, pv}, 1'b0);
			tick(2);
			check("phase_ovr", phase_offset, (pv > msq_pkg::PH_MAX) ? msq_pkg::PH_MAX : pv);
		end
		check("line_up", link_if.line, 1'b1);
		ahb(msq_pkg::A_CTRL, 1'b1, 32'h1);
		wait_sig(0, 1'b1, 1000);
		check("pu_time", n >= TON + TRISE - 10 && n <= TON + TRISE + SKEW + 30, 1'b1);
		tick(100);
		ahb(msq_pkg::A_STAT, 1'b0, 32'h0);
		check("handoff_id", rd[7:4], a[3:0]);
		ahb(msq_pkg::A_IRQ_STAT, 1'b0, 32'h0);
		check("handoff_irq", rd[2], 1'b1);
		ahb(msq_pkg::A_CTRL, 1'b1, 32'h0);
		wait_sig(1, 1'b0, 400);
		check("pd_time", n >= TRISE - 10 && n <= TRISE + 30, 1'b1);
		p = 4'($urandom_range(15));
		cmd(msq_pkg::CMD_SEQ, {6'h00, 2'h1, 4'h0, p}, 1'b0);
		ahb(msq_pkg::A_CTRL, 1'b1, 32'h1);
		ahb(msq_pkg::A_TX, 1'b1, {28'h0, p ^ 4'h1});
		tick(400);
		check("wait_prev", rail_on, 1'b0);
		ahb(msq_pkg::A_TX, 1'b1, {28'h0, p});
		wait_sig(0, 1'b1, 1000);
		check("chain_on", power_good, 1'b1);
		tick(100);
		ahb(msq_pkg::A_IRQ_EN, 1'b1, 32'h0);
		ahb(msq_pkg::A_IRQ_CLR, 1'b1, 32'h7);
		@(posedge clock);
		fault_in <= 1'b1;
		tick(3);
		check("fault_off", rail_on, 1'b0);
		@(posedge clock);
		fault_in <= 1'b0;
		tick(200);
		check("fault_alert", link_if.alert, 1'b1);
		ahb(msq_pkg::A_IRQ_STAT, 1'b0, 32'h0);
		check("fault_stat", rd[1:0], 2'h3);
		check("irq_masked", irq, 1'b0);
		ahb(msq_pkg::A_IRQ_EN, 1'b1, 32'h2);
		tick(2);
		check("irq_on", irq, 1'b1);
		ahb(msq_pkg::A_IRQ_CLR, 1'b1, 32'h2);
		tick(2);
		check("irq_clr", irq, 1'b0);
		ahb(8'hFC, 1'b0, 32'h0);
		check("unmapped", rd, 32'h0);
		check("hresp_okay", hresp, 1'b0);
		cmd(4'h0, 16'h0, 1'b1);
		cmd(msq_pkg::CMD_CLRALERT, 16'h0, 1'b0);
		tick(2);
		check("locked", link_if.alert, 1'b1);
		ahb(msq_pkg::A_CTRL, 1'b1, 32'h0);
		tick(3);
		ahb(msq_pkg::A_CTRL, 1'b1, 32'h1);
		tick(3);
		cmd(msq_pkg::CMD_CLRALERT, 16'h0, 1'b0);
		tick(2);
		check("unlocked", link_if.alert, 1'b0);
		do_reset(a);
		cmd(msq_pkg::CMD_SETUP, {10'h0, msq_pkg::SETUP_RST | 6'h08}, 1'b0);
		ahb(msq_pkg::A_CTRL, 1'b1, 32'h1);
		wait_sig(0, 1'b1, 1000);
		tick(100);
		ahb(msq_pkg::A_TX, 1'b1, 32'h10);
		wait_sig(1, 1'b0, 300);
		check("bcast_off", rail_on, 1'b0);
		wait_sig(0, 1'b1, msq_pkg::RESTART_CYC + TON + TRISE + SKEW + 100);
		check("restart", n >= msq_pkg::RESTART_CYC && power_good === 1'b1, 1'b1);
		check("bcast_alert", link_if.alert, 1'b1);
		do_reset(a);
		cmd(msq_pkg::CMD_SETUP, {10'h0, msq_pkg::SETUP_RST | 6'h20}, 1'b0);
		ahb(msq_pkg::A_CTRL, 1'b1, 32'h3);
		tick(2);
		check("en_held", link_if.en, 1'b0);
		tv = 16'($urandom_range(120, 20));
		rv = 16'($urandom_range(120, 20));
		cmd(msq_pkg::CMD_TON, tv, 1'b0);
		cmd(msq_pkg::CMD_TRISE, rv, 1'b0);
		cmd(msq_pkg::CMD_ONOFF, 16'h1, 1'b0);
		wait_sig(0, 1'b1, 1000);
		check("cmd_on", power_good, 1'b1);
		check("cmd_on_time", n >= tv + rv && n <= tv + rv + SKEW + 30, 1'b1);
		tick(100);
		cmd(msq_pkg::CMD_SETUP, {10'h0, msq_pkg::SETUP_RST | 6'h21}, 1'b0);
		tick(4);
		check("push_pull", {link_if.dev_oe, link_if.dev_o}, 2'h3);
		// Power-down waits for the follower's handoff
		p = 4'($urandom_range(15));
		cmd(msq_pkg::CMD_SEQ, {6'h00, 2'h2, p, 4'h0}, 1'b0);
		cmd(msq_pkg::CMD_ONOFF, 16'h0, 1'b0);
		tick(300);
		check("wait_next", rail_on, 1'b1);
		ahb(msq_pkg::A_TX, 1'b1, {28'h0, p});
		wait_sig(1, 1'b0, 400);
		check("next_off", n >= rv && n <= rv + 100, 1'b1);
		summarize();
	end
endmodule
